// ==== src/acr_pkg.sv ====
// constants for the converter configuration register slice
package acr_pkg;
  // register offsets on the configuration port
  localparam logic [14:0] ADDR_SUPPLY_NOISE = 15'h002b;
  localparam logic [14:0] ADDR_SYNC_POS = 15'h002c;
  localparam logic [14:0] ADDR_FULLSCALE_CODE = 15'h0030;
  localparam logic [14:0] ADDR_POWER1 = 15'h0037;
  // reset values
  localparam logic [7:0] RST_SUPPLY_NOISE = 8'h10;
  localparam logic [23:0] RST_SYNC_POS = 24'h000000;
  localparam logic [15:0] RST_FULLSCALE_CODE = 16'ha000;
  localparam logic [7:0] RST_POWER1 = 8'h4b;
  // field positions in the supply noise register
  localparam int BIT_ANALOG_QUIET = 2;
  localparam int BIT_CLOCK_QUIET = 0;
  // power profile codes and the recommended full-scale minimum
  localparam logic [7:0] PROFILE_LOW_POWER = 8'h46;
  localparam logic [7:0] PROFILE_HIGH_PERF = 8'h4b;
  localparam logic [15:0] FS_MIN_RECOMMENDED = 16'h2000;
  // sync delay select width
  localparam int SYNC_SEL_W = 4;
  // serial command width: read flag, 15 address bits
  localparam int CMD_W = 16;
  localparam int ADDR_W = 15;
endpackage

// ==== src/acr_sync2.sv ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module acr_sync2 #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage1;

  // first stage is read only by the second
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

// ==== src/acr_regs.sv ====
// configuration register slice with its serial configuration port
`timescale 1ns/1ps
//
// Summary of operation
// - bit 2 enables analog rail noise suppression
// - bit 0 enables clock rail noise suppression
// - read-only 24-bit sync edge position
// - 16-bit full-scale code, resets 0xa000
// - power profile codes 0x46 low, 0x4b high
// - four-bit sync delay select chooses delay
module acr_regs
  import acr_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cfg_sclk,
  input wire logic cfg_cs_n,
  input wire logic cfg_sdi,
  output logic cfg_sdo,
  output logic cfg_sdo_oe,
  input wire logic [23:0] sync_edge_position,
  input wire logic [SYNC_SEL_W-1:0] sync_delay_select,
  output logic analog_rail_quiet_en,
  output logic clock_rail_quiet_en,
  output logic [15:0] fullscale_code,
  output logic [7:0] power_profile_code1,
  output logic low_power_active,
  output logic fs_below_recommended,
  output logic [SYNC_SEL_W-1:0] sync_delay_applied
);
  // ==========================================================
  // pin synchronisers
  logic [2:0] pins_raw;
  logic [2:0] pins_s;
  logic sclk_s;
  logic cs_n_s;
  logic sdi_s;
  assign pins_raw = {cfg_sclk, cfg_cs_n, cfg_sdi};

  acr_sync2 #(.W(3)) u_sync_pins (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .din(pins_raw),
    .dout(pins_s)
  );
  assign sclk_s = pins_s[2];
  assign cs_n_s = pins_s[1];
  assign sdi_s = pins_s[0];

  // the measured position is a slow analog status; synchronise it whole
  logic [23:0] pos_s;
  acr_sync2 #(.W(24)) u_sync_pos (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .din(sync_edge_position),
    .dout(pos_s)
  );

  // the delay select lives in another register; synchronise it too
  logic [SYNC_SEL_W-1:0] sel_s;
  acr_sync2 #(.W(SYNC_SEL_W)) u_sync_sel (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .din(sync_delay_select),
    .dout(sel_s)
  );

  // ==========================================================
  // serial frame engine: 16 command bits, then data bytes
  typedef enum logic [1:0] {
    ACR_IDLE = 2'b00,
    ACR_CMD = 2'b01,
    ACR_DATA = 2'b10
  } acr_state_t;

  acr_state_t state;
  logic sclk_d;
  logic rise;
  logic fall;
  logic [CMD_W-1:0] shreg;
  logic [4:0] bitcnt;
  logic rd;
  logic [ADDR_W-1:0] addr;
  logic [7:0] txbyte;
  logic wr_pulse;
  logic [7:0] wr_data;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] rd_byte;

  assign rise = sclk_s & ~sclk_d;
  assign fall = ~sclk_s & sclk_d;

  // edge detect on the synchronised clock only
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
    end
  end

  // shifting and address stepping; address ascends across streamed bytes
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state <= ACR_IDLE;
      shreg <= '0;
      bitcnt <= 5'h00;
      rd <= 1'b0;
      addr <= '0;
      wr_pulse <= 1'b0;
      wr_data <= 8'h00;
      wr_addr <= '0;
    end else begin
      wr_pulse <= 1'b0;
      if (cs_n_s) begin
        state <= ACR_IDLE;
        bitcnt <= 5'h00;
      end else begin
        case (state)
          ACR_IDLE: begin
            state <= ACR_CMD;
            bitcnt <= 5'h00;
          end
          ACR_CMD: begin
            if (rise) begin
              shreg <= {shreg[CMD_W-2:0], sdi_s};
              if (bitcnt == 5'(CMD_W - 1)) begin
                rd <= shreg[CMD_W-2];
                addr <= {shreg[ADDR_W-2:0], sdi_s};
                bitcnt <= 5'h00;
                state <= ACR_DATA;
              end else begin
                bitcnt <= bitcnt + 5'h01;
              end
            end
          end
          ACR_DATA: begin
            if (rise) begin
              shreg <= {shreg[CMD_W-2:0], sdi_s};
              if (bitcnt == 5'h07) begin
                bitcnt <= 5'h00;
                addr <= addr + 15'h0001;
                wr_pulse <= ~rd;
                wr_data <= {shreg[6:0], sdi_s};
                wr_addr <= addr;
              end else begin
                bitcnt <= bitcnt + 5'h01;
              end
            end
          end
          default: state <= ACR_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // register storage
  logic [7:0] supply_noise_ctrl;
  logic [15:0] fullscale_range_adjust;
  logic [7:0] power_profile_select1;

  // writable registers; multi-byte registers are big-endian in address
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      supply_noise_ctrl <= RST_SUPPLY_NOISE;
      fullscale_range_adjust <= RST_FULLSCALE_CODE;
      power_profile_select1 <= RST_POWER1;
    end else if (wr_pulse) begin
      case (wr_addr)
        // reserved bits are stored as written; keeping them default is
        // software's job, the device does not police them
        ADDR_SUPPLY_NOISE: supply_noise_ctrl <= wr_data;
        ADDR_FULLSCALE_CODE: fullscale_range_adjust[15:8] <= wr_data;
        ADDR_FULLSCALE_CODE + 15'h0001:
          fullscale_range_adjust[7:0] <= wr_data;
        // reserved codes are stored; decode below treats them as high perf
        ADDR_POWER1: power_profile_select1 <= wr_data;
        // position register offsets fall through: writes ignored
        default: supply_noise_ctrl <= supply_noise_ctrl;
      endcase
    end
  end

  // read mux; each position byte is read live with no snapshot, unmapped reads give zero
  always_comb begin
    case (addr)
      ADDR_SUPPLY_NOISE: rd_byte = supply_noise_ctrl;
      ADDR_SYNC_POS: rd_byte = pos_s[23:16];
      ADDR_SYNC_POS + 15'h0001: rd_byte = pos_s[15:8];
      ADDR_SYNC_POS + 15'h0002: rd_byte = pos_s[7:0];
      ADDR_FULLSCALE_CODE: rd_byte = fullscale_range_adjust[15:8];
      ADDR_FULLSCALE_CODE + 15'h0001: rd_byte = fullscale_range_adjust[7:0];
      ADDR_POWER1: rd_byte = power_profile_select1;
      default: rd_byte = 8'h00;
    endcase
  end

  // serial output: load each data byte at its start, shift out on falling edges
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      txbyte <= 8'h00;
      cfg_sdo <= 1'b0;
      cfg_sdo_oe <= 1'b0;
    end else begin
      cfg_sdo_oe <= ~cs_n_s & rd & (state == ACR_DATA);
      if (state == ACR_DATA && rd && fall) begin
        if (bitcnt == 5'h00) begin
          cfg_sdo <= rd_byte[7];
          txbyte <= {rd_byte[6:0], 1'b0};
        end else begin
          cfg_sdo <= txbyte[7];
          txbyte <= {txbyte[6:0], 1'b0};
        end
      end
    end
  end

  // ==========================================================
  // control outputs registered from the fields
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      analog_rail_quiet_en <= 1'b0;
      clock_rail_quiet_en <= 1'b0;
      fullscale_code <= RST_FULLSCALE_CODE;
      power_profile_code1 <= RST_POWER1;
      low_power_active <= 1'b0;
      fs_below_recommended <= 1'b0;
      sync_delay_applied <= '0;
    end else begin
      analog_rail_quiet_en <= supply_noise_ctrl[BIT_ANALOG_QUIET];
      clock_rail_quiet_en <= supply_noise_ctrl[BIT_CLOCK_QUIET];
      fullscale_code <= fullscale_range_adjust;
      power_profile_code1 <= power_profile_select1;
      low_power_active <=
        (power_profile_select1 == PROFILE_LOW_POWER);
      // flag only; low codes are still applied
      fs_below_recommended <=
        (fullscale_range_adjust < FS_MIN_RECOMMENDED);
      sync_delay_applied <= sel_s;
    end
  end

  // ==========================================================
  // checks
  a_analog_quiet_follow: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    ##1 analog_rail_quiet_en == $past(supply_noise_ctrl[BIT_ANALOG_QUIET]))
    else $error("analog rail enable does not follow bit");
  a_clock_quiet_follow: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    ##1 clock_rail_quiet_en == $past(supply_noise_ctrl[BIT_CLOCK_QUIET]))
    else $error("clock rail enable does not follow bit");
  a_pos_read_value: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    (addr == ADDR_SYNC_POS) |-> rd_byte == pos_s[23:16])
    else $error("position high byte read wrong");
  a_fs_code_out: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    wr_pulse && wr_addr == ADDR_FULLSCALE_CODE |=> ##1
      fullscale_code[15:8] == $past(wr_data, 2))
    else $error("full-scale high byte not applied");
  a_low_power_dec: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    wr_pulse && wr_addr == ADDR_POWER1 |=> ##1
      low_power_active == ($past(wr_data, 2) == PROFILE_LOW_POWER))
    else $error("low power decode wrong");
  a_sel_applied: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    ##1 sync_delay_applied == $past(sel_s))
    else $error("delay select not applied");
  a_pos_write_ignored: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    wr_pulse && wr_addr == ADDR_SYNC_POS |=> $stable(supply_noise_ctrl)
      && $stable(fullscale_range_adjust) && $stable(power_profile_select1))
    else $error("write to position register changed state");
endmodule

// ==== testbench/test_acr_regs.sv ====
// self-checking testbench for the converter configuration register slice
`timescale 1ns/1ps
module test_acr_regs;
  import acr_pkg::*;
  // sclk phase in core cycles, twice the minimum so the syncs settle
  localparam int HALF = 8;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cfg_sclk = 1'b0;
  logic cfg_cs_n = 1'b1;
  logic cfg_sdi = 1'b0;
  logic cfg_sdo;
  logic cfg_sdo_oe;
  logic [23:0] sync_edge_position = 24'h000000;
  logic [SYNC_SEL_W-1:0] sync_delay_select = '0;
  logic analog_rail_quiet_en;
  logic clock_rail_quiet_en;
  logic [15:0] fullscale_code;
  logic [7:0] power_profile_code1;
  logic low_power_active;
  logic fs_below_recommended;
  logic [SYNC_SEL_W-1:0] sync_delay_applied;
  logic [7:0] v;
  // last full-scale entry keeps a non-zero high byte for the low-byte test
  logic [15:0] fs_tab [4] = '{16'h1fff, 16'h2000, 16'h0000, 16'hffff};
  // low power last, so the mid-run reset has a default to restore
  logic [7:0] pp_tab [3] = '{8'h4b, 8'h47, 8'h46};
  logic oe_seen;
  int num_errors = 0;
  int cmp_count = 0;

  acr_regs dut_u (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .cfg_sclk(cfg_sclk),
    .cfg_cs_n(cfg_cs_n),
    .cfg_sdi(cfg_sdi),
    .cfg_sdo(cfg_sdo),
    .cfg_sdo_oe(cfg_sdo_oe),
    .sync_edge_position(sync_edge_position),
    .sync_delay_select(sync_delay_select),
    .analog_rail_quiet_en(analog_rail_quiet_en),
    .clock_rail_quiet_en(clock_rail_quiet_en),
    .fullscale_code(fullscale_code),
    .power_profile_code1(power_profile_code1),
    .low_power_active(low_power_active),
    .fs_below_recommended(fs_below_recommended),
    .sync_delay_applied(sync_delay_applied)
  );

  // ==========================================================
  // clock and helpers
  always #10 core_clk = ~core_clk;

  // inputs always move 2 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one frame: 16 command bits then nb bytes, msb first; read bits are
  // taken at the end of each low phase, long after sdo has moved
  task automatic xfer(input logic [15:0] cmd, input int nb,
                      input logic [23:0] wd, output logic [23:0] rdat);
    logic [39:0] bits;
    // data is left aligned under the command, never shifted over it
    bits = {cmd, wd << (8 * (3 - nb))};
    rdat = '0;
    cfg_cs_n = 1'b0;
    tick(HALF);
    for (int i = 0; i < 16 + 8 * nb; i++) begin
      cfg_sdi = bits[39 - i];
      tick(HALF);
      if (i >= 16) rdat = {rdat[22:0], cfg_sdo};
      if (i == 16) oe_seen = cfg_sdo_oe;
      cfg_sclk = 1'b1;
      tick(HALF);
      cfg_sclk = 1'b0;
    end
    tick(HALF);
    cfg_cs_n = 1'b1;
    tick(HALF);
  endtask

  task automatic wr(input logic [14:0] a, input int nb,
                    input logic [23:0] d);
    logic [23:0] dummy;
    xfer({1'b0, a}, nb, d, dummy);
  endtask

  task automatic rd_chk(input logic [14:0] a, input int nb,
                        input logic [23:0] e);
    logic [23:0] got;
    xfer({1'b1, a}, nb, 24'h0, got);
    check(got, e);
    check(oe_seen, 1'b1);
  endtask

  task automatic reset_vals;
    check(analog_rail_quiet_en, 1'b0);
    check(clock_rail_quiet_en, 1'b0);
    check(fullscale_code, 16'ha000);
    check(power_profile_code1, 8'h4b);
    check(low_power_active, 1'b0);
    check(fs_below_recommended, 1'b0);
    check(cfg_sdo_oe, 1'b0);
    rd_chk(ADDR_SUPPLY_NOISE, 1, 24'h10);
    rd_chk(ADDR_FULLSCALE_CODE, 2, 24'ha000);
  endtask

  task automatic wrap_up;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog at 60k cycles, well beyond the roughly 16k the tests need
  initial begin
    #1200000;
    num_errors++;
    wrap_up();
  end

  // ==========================================================
  // main sequence
  initial begin
    tick(12);
    reset_n = 1'b1;
    tick(6);
    reset_vals();
    // reserved bits always written as their default 0x10
    for (int k = 0; k < 4; k++) begin
      v = 8'h10 | {5'h0, k[1], 1'b0, k[0]};
      wr(ADDR_SUPPLY_NOISE, 1, {16'h0, v});
      check(analog_rail_quiet_en, k[1]);
      check(clock_rail_quiet_en, k[0]);
      rd_chk(ADDR_SUPPLY_NOISE, 1, {16'h0, v});
    end
    // boundary codes around the recommended minimum and the maximum
    foreach (fs_tab[j]) begin
      wr(ADDR_FULLSCALE_CODE, 2, {8'h0, fs_tab[j]});
      check(fullscale_code, fs_tab[j]);
      check(fs_below_recommended, fs_tab[j] < 16'h2000);
      rd_chk(ADDR_FULLSCALE_CODE, 2, {8'h0, fs_tab[j]});
    end
    // low byte alone must leave the high byte untouched
    wr(ADDR_FULLSCALE_CODE + 15'h1, 1, 24'h5a);
    check(fullscale_code, 16'hff5a);
    check(fs_below_recommended, 1'b0);
    // calibration and link enables live elsewhere and stay off here
    // the three companion profile registers sit outside this slice
    // no conversion result is relied on after a mode change
    foreach (pp_tab[j]) begin
      wr(ADDR_POWER1, 1, {16'h0, pp_tab[j]});
      check(power_profile_code1, pp_tab[j]);
      check(low_power_active, pp_tab[j] == 8'h46);
      rd_chk(ADDR_POWER1, 1, {16'h0, pp_tab[j]});
    end
    sync_edge_position = 24'h5a3c81;
    tick(4);
    rd_chk(ADDR_SYNC_POS, 3, 24'h5a3c81);
    wr(ADDR_SYNC_POS, 3, 24'ha5c37e);
    rd_chk(ADDR_SYNC_POS, 3, 24'h5a3c81);
    rd_chk(ADDR_SYNC_POS + 15'h2, 1, 24'h000081);
    sync_edge_position = 24'h00ff00;
    tick(4);
    rd_chk(ADDR_SYNC_POS, 3, 24'h00ff00);
    rd_chk(15'h0040, 1, 24'h000000);
    for (int s = 0; s < 16; s++) begin
      sync_delay_select = s[SYNC_SEL_W-1:0];
      tick(5);
      check(sync_delay_applied, s[SYNC_SEL_W-1:0]);
    end
    // second reset in mid-run must restore every default
    reset_n = 1'b0;
    tick(3);
    check(sync_delay_applied, 4'h0);
    reset_n = 1'b1;
    tick(6);
    reset_vals();
    wrap_up();
  end
endmodule
